// file: hw/osc_trim_pkg.sv
// Purpose: Shared constants for the oscillator trim and clock switch block
// Assumes: AXI4-Lite register bus, 32-bit data, 8-bit byte address
// Notes: Source select codes follow the two-bit field of the config register
package osc_trim_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register byte offsets
    localparam logic [7:0] TRIM_OFFSET = 8'h00;
    localparam logic [7:0] CONFIG_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    // Reset values
    localparam logic [7:0] TRIM_RESET = 8'h80;
    localparam logic [1:0] SOURCE_RESET = 2'h0;
    // Config field positions
    localparam int SRC_LSB = 0;
    localparam int PA4_DIR_BIT = 2;
    localparam int PA4_LEVEL_BIT = 3;
    // Status field positions
    localparam int REQ_BIT = 0;
    localparam int ACTIVE_BIT = 1;
    localparam int INT_RUN_BIT = 2;
    localparam int EXT_SEL_BIT = 3;
    // Source select codes
    localparam logic [1:0] SRC_INTERNAL = 2'h0;
    localparam logic [1:0] SRC_CRYSTAL = 2'h3;
    // Internal oscillator: half period in mclk cycles is HALF_BASE + trim
    localparam logic [8:0] HALF_BASE = 9'h080;
    // Edges of the external clock seen before the changeover
    localparam logic [1:0] EDGES_NEEDED = 2'h2;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CHECK = 5'h02,
        ST_SWITCH = 5'h04,
        ST_ACTIVE = 5'h08,
        ST_EXT = 5'h10
    } switch_state_e;
endpackage

// file: hw/osc_trim_and_clock_switch.sv
// Purpose: Internal oscillator trim and glitch-free change to an external clock
// Assumes: External clock slower than mclk/4, seen on osc_in_pin through two flops
// Notes: Internal oscillator modelled as a divided clock; stopped until reset
//
// Summary of operation
// - Eight-bit trim sets oscillator half period, unsigned: HALF_BASE plus 0 to 255 mclk cycles.
// - Larger trim value gives a longer internal oscillator period.
// - Trim never loads itself; software copies the factory value if wanted.
// - External source selected makes osc_in an input; crystal also drives osc_out.
// - After the request, two external rising edges are seen before switching.
// - Changeover at an external falling edge inside the internal low phase.
// - Active flag is set first, internal oscillator stopped afterwards.
// - Internal oscillator stays stopped until reset.
// - No clock monitor after the switch and no fallback.
`timescale 1ns/100ps
module osc_trim_and_clock_switch (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic osc_in_pin,
    output logic osc_in_enable,
    output logic osc_out_pin_o,
    output logic osc_out_pin_oe,
    output logic sys_clk_out,
    output logic sys_clk_ext_sel,
    output logic int_osc_run
);
    logic [7:0] osc_period_trim;
    logic [1:0] osc_source_select;
    logic pa4_dir;
    logic pa4_level;
    logic ext_clock_request;
    logic ext_clock_active_flag;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
    logic ext_rise;
    logic int_clk;
    logic [8:0] int_cnt;
    logic [8:0] half_period;
    logic [1:0] edge_cnt;
    osc_trim_pkg::switch_state_e state;

    assign wr_fire = aw_got && w_got && !s_axi_bvalid;
    assign ext_rise = ext_sync && !ext_prev;
    assign half_period = osc_trim_pkg::HALF_BASE + {1'b0, osc_period_trim};

    // Write address and data capture, response
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                if (aw_addr == osc_trim_pkg::TRIM_OFFSET || aw_addr == osc_trim_pkg::CONFIG_OFFSET
                    || aw_addr == osc_trim_pkg::STATUS_OFFSET) begin
                    s_axi_bresp <= osc_trim_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= osc_trim_pkg::RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Trim register, written only by software
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            osc_period_trim <= osc_trim_pkg::TRIM_RESET;
        end else if (wr_fire && aw_addr == osc_trim_pkg::TRIM_OFFSET && w_strb[0]) begin
            osc_period_trim <= w_data[7:0];
        end
    end

    // Source select and port line four control
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            osc_source_select <= osc_trim_pkg::SOURCE_RESET;
            pa4_dir <= 1'b0;
            pa4_level <= 1'b0;
        end else if (wr_fire && aw_addr == osc_trim_pkg::CONFIG_OFFSET && w_strb[0]) begin
            osc_source_select <= w_data[osc_trim_pkg::SRC_LSB +: 2];
            pa4_dir <= w_data[osc_trim_pkg::PA4_DIR_BIT];
            pa4_level <= w_data[osc_trim_pkg::PA4_LEVEL_BIT];
        end
    end

    // Changeover request bit
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ext_clock_request <= 1'b0;
        end else if (wr_fire && aw_addr == osc_trim_pkg::STATUS_OFFSET && w_strb[0]) begin
            ext_clock_request <= w_data[osc_trim_pkg::REQ_BIT];
        end
    end

    // Read channel
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= osc_trim_pkg::RESP_OKAY;
            if (s_axi_araddr == osc_trim_pkg::TRIM_OFFSET) begin
                s_axi_rdata <= {24'h00_0000, osc_period_trim};
            end else if (s_axi_araddr == osc_trim_pkg::CONFIG_OFFSET) begin
                s_axi_rdata <= {28'h000_0000, pa4_level, pa4_dir, osc_source_select};
            end else if (s_axi_araddr == osc_trim_pkg::STATUS_OFFSET) begin
                s_axi_rdata <= {28'h000_0000, sys_clk_ext_sel, int_osc_run,
                                ext_clock_active_flag, ext_clock_request};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= osc_trim_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // External clock synchroniser and edge history
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= osc_in_pin;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    // Internal oscillator, half period grows with trim
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            int_cnt <= 9'h000;
            int_clk <= 1'b0;
        end else if (!int_osc_run) begin
            int_cnt <= 9'h000;
            int_clk <= 1'b0;
        end else if (int_cnt == 9'h000) begin
            int_cnt <= half_period - 9'h001;
            int_clk <= !int_clk;
        end else begin
            int_cnt <= int_cnt - 9'h001;
        end
    end

    // Changeover sequence
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= osc_trim_pkg::ST_IDLE;
            edge_cnt <= 2'h0;
            sys_clk_ext_sel <= 1'b0;
            ext_clock_active_flag <= 1'b0;
            int_osc_run <= 1'b1;
        end else begin
            case (state)
                osc_trim_pkg::ST_IDLE: begin
                    edge_cnt <= 2'h0;
                    if (ext_clock_request && osc_source_select != osc_trim_pkg::SRC_INTERNAL) begin
                        state <= osc_trim_pkg::ST_CHECK;
                    end
                end
                osc_trim_pkg::ST_CHECK: begin
                    if (!ext_clock_request) begin
                        state <= osc_trim_pkg::ST_IDLE;
                    end else if (ext_rise) begin
                        edge_cnt <= edge_cnt + 2'h1;
                        if (edge_cnt + 2'h1 == osc_trim_pkg::EDGES_NEEDED) begin
                            state <= osc_trim_pkg::ST_SWITCH;
                        end
                    end
                end
                osc_trim_pkg::ST_SWITCH: begin
                    if (!int_clk && ext_prev && !ext_sync) begin
                        sys_clk_ext_sel <= 1'b1;
                        ext_clock_active_flag <= 1'b1;
                        state <= osc_trim_pkg::ST_ACTIVE;
                    end
                end
                osc_trim_pkg::ST_ACTIVE: begin
                    int_osc_run <= 1'b0;
                    state <= osc_trim_pkg::ST_EXT;
                end
                osc_trim_pkg::ST_EXT: begin
                    state <= osc_trim_pkg::ST_EXT;
                end
                default: begin
                    state <= osc_trim_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Selected system clock and pin control
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sys_clk_out <= 1'b0;
            osc_in_enable <= 1'b0;
            osc_out_pin_o <= 1'b0;
            osc_out_pin_oe <= 1'b0;
        end else begin
            sys_clk_out <= sys_clk_ext_sel ? ext_sync : int_clk;
            osc_in_enable <= osc_source_select != osc_trim_pkg::SRC_INTERNAL;
            if (osc_source_select == osc_trim_pkg::SRC_CRYSTAL) begin
                osc_out_pin_oe <= 1'b1;
                osc_out_pin_o <= !ext_sync;
            end else begin
                osc_out_pin_oe <= pa4_dir;
                osc_out_pin_o <= pa4_level;
            end
        end
    end

    // Checks
    a_trim_write_only: assert property (@(posedge mclk) disable iff (!resetn)
        $changed(osc_period_trim) |-> $past(wr_fire && aw_addr == osc_trim_pkg::TRIM_OFFSET))
        else $error("trim changed without a write");
    a_trim_reload: assert property (@(posedge mclk) disable iff (!resetn)
        (int_osc_run && int_cnt == 9'h000) ##1 int_osc_run |-> int_cnt == $past(half_period) - 9'h001)
        else $error("oscillator half period wrong");
    a_period_monotone: assert property (@(posedge mclk) disable iff (!resetn)
        $changed(osc_period_trim) && osc_period_trim > $past(osc_period_trim)
        |-> half_period > $past(half_period))
        else $error("half period not following trim");
    a_in_enable: assert property (@(posedge mclk) disable iff (!resetn)
        (osc_source_select == osc_trim_pkg::SRC_CRYSTAL) |=> osc_in_enable && osc_out_pin_oe)
        else $error("crystal pins not configured");
    a_two_edges_seen: assert property (@(posedge mclk) disable iff (!resetn)
        (state == osc_trim_pkg::ST_CHECK && ext_rise && edge_cnt == 2'h0 && ext_clock_request)
        |=> state == osc_trim_pkg::ST_CHECK)
        else $error("switched after one edge");
    a_switch_both_low: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(sys_clk_ext_sel) |-> $past(!int_clk && ext_prev && !ext_sync))
        else $error("clock changeover not in low phase");
    a_flag_before_stop: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(int_osc_run) |-> $past(ext_clock_active_flag) && $past(ext_clock_active_flag, 2) == 1'b0)
        else $error("oscillator stopped out of order");
    a_osc_stays_off: assert property (@(posedge mclk) disable iff (!resetn)
        !int_osc_run |=> !int_osc_run [*8])
        else $error("internal oscillator restarted");
    a_no_fallback: assert property (@(posedge mclk) disable iff (!resetn)
        sys_clk_ext_sel |=> sys_clk_ext_sel && state == osc_trim_pkg::ST_EXT)
        else $error("clock fell back to internal");
    a_flag_held: assert property (@(posedge mclk) disable iff (!resetn)
        ext_clock_active_flag |=> ext_clock_active_flag && sys_clk_ext_sel)
        else $error("active flag dropped");
    c_switch_done: cover property (@(posedge mclk) disable iff (!resetn) $fell(int_osc_run));
    c_check_abort: cover property (@(posedge mclk) disable iff (!resetn)
        state == osc_trim_pkg::ST_CHECK ##1 state == osc_trim_pkg::ST_IDLE);
    c_trim_write: cover property (@(posedge mclk) disable iff (!resetn) $changed(osc_period_trim));
    c_bad_read: cover property (@(posedge mclk) disable iff (!resetn)
        s_axi_rvalid && s_axi_rresp == osc_trim_pkg::RESP_SLVERR);
endmodule

// file: sim/ext_clock_source.sv
// Purpose: External clock source seen at the oscillator input pin
// Assumes: Half period well above four mclk periods
// Notes: Holds the pin low while stopped, as a dead oscillator would
`timescale 1ns/100ps
module ext_clock_source #(
    parameter realtime HALF_NS = 41.3
) (
    input wire logic run,
    output logic clk_out
);
    initial clk_out = 1'b0;
    // Free-running source, phase unrelated to mclk
    always begin
        #(HALF_NS);
        clk_out = run ? ~clk_out : 1'b0;
    end
endmodule

// file: sim/osc_trim_and_clock_switch_tb_top.sv
// Purpose: Self-checking bench for the oscillator trim and clock switch block
// Assumes: AXI4-Lite master tasks, external source from ext_clock_source
// Notes: Stabilization wait shortened to keep the run brief
`timescale 1ns/100ps
module osc_trim_and_clock_switch_tb_top;
    localparam int STAB_CYCLES = 16;
    localparam int LIMIT = 20000;
    logic mclk, resetn, ext_run;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic osc_in_pin, osc_in_enable, osc_out_pin_o, osc_out_pin_oe;
    logic sys_clk_out, sys_clk_ext_sel, int_osc_run, last_clk;
    int errors, cmp_count, cycles, ext_rises, phase_len, phase_seen, n, r0;
    logic [7:0] trims [3] = '{8'h00, 8'h80, 8'hFF};
    logic [7:0] cfgs [3] = '{8'h0C, 8'h01, 8'h03};
    logic [1:0] pins [3] = '{2'b01, 2'b10, 2'b11};

    osc_trim_and_clock_switch osc_trim_and_clock_switch_i (
        .mclk(mclk), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .osc_in_pin(osc_in_pin),
        .osc_in_enable(osc_in_enable), .osc_out_pin_o(osc_out_pin_o),
        .osc_out_pin_oe(osc_out_pin_oe), .sys_clk_out(sys_clk_out),
        .sys_clk_ext_sel(sys_clk_ext_sel), .int_osc_run(int_osc_run)
    );

    ext_clock_source ext_clock_source_i (.run(ext_run), .clk_out(osc_in_pin));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic tally_and_finish;
        $display("compares %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic do_reset;
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check32(s_axi_bresp, er);
        @(posedge mclk);
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check32(s_axi_rdata, ed);
        check32(s_axi_rresp, er);
        @(posedge mclk);
    endtask

    // Cycles of one phase of the modelled system clock
    task automatic half_period(output int len);
        logic v;
        v = sys_clk_out;
        do @(posedge mclk); while (sys_clk_out === v);
        v = sys_clk_out;
        len = 0;
        do begin
            @(posedge mclk);
            len++;
        end while (sys_clk_out === v);
    endtask

    always @(posedge osc_in_pin) ext_rises++;

    // Minimum phase width watch across the whole run
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            phase_len = 0;
            phase_seen = 0;
            last_clk = 1'b0;
        end else if (sys_clk_out !== last_clk) begin
            if (phase_seen && phase_len < 8) check32(phase_len, 8);
            phase_seen = 1;
            phase_len = 1;
            last_clk = sys_clk_out;
        end else begin
            phase_len++;
        end
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            tally_and_finish();
        end
    end

    initial begin
        ext_run = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        do_reset();
        axi_read(osc_trim_pkg::TRIM_OFFSET, 32'h80, osc_trim_pkg::RESP_OKAY);
        axi_read(8'h0C, 32'h0, osc_trim_pkg::RESP_SLVERR);
        axi_write(8'h0C, 32'h5, osc_trim_pkg::RESP_SLVERR);
        foreach (trims[i]) begin
            axi_write(osc_trim_pkg::TRIM_OFFSET, {24'h0, trims[i]}, osc_trim_pkg::RESP_OKAY);
            axi_read(osc_trim_pkg::TRIM_OFFSET, {24'h0, trims[i]}, osc_trim_pkg::RESP_OKAY);
            half_period(n);
            half_period(n);
            check32(n, 32'(osc_trim_pkg::HALF_BASE) + trims[i]);
        end
        // Request with internal source only, flag write ignored
        axi_write(osc_trim_pkg::STATUS_OFFSET, 32'h3, osc_trim_pkg::RESP_OKAY);
        repeat (600) @(posedge mclk);
        check32(sys_clk_ext_sel, 1'b0);
        axi_read(osc_trim_pkg::STATUS_OFFSET, 32'h5, osc_trim_pkg::RESP_OKAY);
        axi_write(osc_trim_pkg::STATUS_OFFSET, 32'h0, osc_trim_pkg::RESP_OKAY);
        foreach (cfgs[i]) begin
            axi_write(osc_trim_pkg::CONFIG_OFFSET, {24'h0, cfgs[i]}, osc_trim_pkg::RESP_OKAY);
            repeat (3) @(posedge mclk);
            check32({osc_in_enable, osc_out_pin_oe}, pins[i]);
            check32(osc_out_pin_o, i != 1);
        end
        // Dead source: request must not switch, then abort it
        axi_write(osc_trim_pkg::STATUS_OFFSET, 32'h1, osc_trim_pkg::RESP_OKAY);
        repeat (100) @(posedge mclk);
        check32(sys_clk_ext_sel, 1'b0);
        axi_write(osc_trim_pkg::STATUS_OFFSET, 32'h0, osc_trim_pkg::RESP_OKAY);
        ext_run <= 1'b1;
        repeat (STAB_CYCLES) @(posedge osc_in_pin);
        // Start just after a pin fall so every counted rise follows r0
        @(negedge osc_in_pin);
        @(posedge mclk);
        axi_write(osc_trim_pkg::STATUS_OFFSET, 32'h1, osc_trim_pkg::RESP_OKAY);
        r0 = ext_rises;
        do @(posedge mclk); while (sys_clk_ext_sel !== 1'b1);
        check32(ext_rises - r0 >= 2, 1);
        check32(int_osc_run, 1'b1);
        @(posedge mclk);
        check32(int_osc_run, 1'b0);
        axi_read(osc_trim_pkg::STATUS_OFFSET, 32'hB, osc_trim_pkg::RESP_OKAY);
        axi_write(osc_trim_pkg::STATUS_OFFSET, 32'h0, osc_trim_pkg::RESP_OKAY);
        axi_read(osc_trim_pkg::STATUS_OFFSET, 32'hA, osc_trim_pkg::RESP_OKAY);
        ext_run <= 1'b0;
        repeat (400) @(posedge mclk);
        check32({sys_clk_ext_sel, int_osc_run}, 2'b10);
        do_reset();
        axi_read(osc_trim_pkg::STATUS_OFFSET, 32'h4, osc_trim_pkg::RESP_OKAY);
        axi_read(osc_trim_pkg::TRIM_OFFSET, 32'h80, osc_trim_pkg::RESP_OKAY);
        tally_and_finish();
    end
endmodule
